// ### rtl/mac_rx_filter_tx_status.sv
/*
  receive acceptance filter, transmit interrupt enables and transmit outcome register
  of a 10 Mb/s mac, with an apb slave for the registers.
  assumes receive and transmit engines on the same clock give one-cycle pulses;
  carrier sense and collision come from the transceiver pins and are synchronised here.
*/
`timescale 1ns/1ps
module mac_rx_filter_tx_status
  import mac_filter_pkg::*;
#(
  parameter int unsigned JABBER_CYCLES = JABBER_CYC
) (
  // clock, reset, enable
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CE_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // configuration load
  input  wire logic        CFG_LOAD_IN,
  input  wire logic [15:0] CFG_RX_CTL_IN,
  input  wire logic [15:0] CFG_TX_EN_IN,
  // receive frame summary
  input  wire logic        RX_DONE_IN,
  input  wire logic [47:0] RX_DEST_IN,
  input  wire logic        RX_HASH_HIT_IN,
  input  wire logic        RX_CHECK_OK_IN,
  input  wire logic [15:0] RX_LENGTH_IN,
  output logic             RX_ACCEPT_OUT,
  output logic             RX_DISCARD_OUT,
  output logic             RX_TRUNCATE_OUT,
  // transmit engine
  input  wire logic        TX_START_IN,
  input  wire logic        TX_FIRST_IN,
  input  wire logic        TX_AUI_IN,
  input  wire logic        TX_PREAMBLE_END_IN,
  input  wire logic        TX_END_IN,
  output logic             TX_ABORT_OUT,
  output logic             TX_FORCE_BAD_CHECK_OUT,
  output logic             TX_GIVE_UP_OUT,
  output logic             TX_IRQ_OUT,
  // transceiver pins
  input  wire logic        CARRIER_SENSE_IN,
  input  wire logic        COLLISION_IN
);

  logic [9:0]  rx_ctl_q;
  logic [9:0]  tx_en_q;
  logic [15:0] sta0_q;
  logic [15:0] sta1_q;
  logic [15:0] sta2_q;
  logic [9:0]  out_q;
  logic        out_dirty_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [1:0]  crs_sync_q;
  logic [1:0]  col_sync_q;
  logic        col_last_q;
  tx_state_t   state_q;
  tx_state_t   state_d;
  logic [10:0] bit_cnt_q;
  logic [19:0] jab_cnt_q;
  logic [7:0]  sqe_cnt_q;
  logic [4:0]  coll_q;
  logic [4:0]  coll_d;
  logic        loss_q;
  logic        aui_q;
  logic        commit;
  logic        ev_ok;
  logic        ev_sqe;
  logic        ev_late;
  logic        ev_jab;
  logic        ev_max;
  logic        abort_now;
  logic        rx_acc_q;
  logic        rx_dis_q;
  logic        rx_trunc_q;
  logic        irq_q;
  logic        abort_q;
  logic        badchk_q;
  logic        giveup_q;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge16 = old;
    if (st[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (st[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // register index from a byte address
  function automatic logic [11:0] reg_index(input logic [11:0] a);
    reg_index = {2'h0, a[11:ADDR_SHIFT]};
  endfunction

  // apb phases
  logic        setup_ph;
  logic        access_done;
  logic [11:0] idx;
  logic        mapped;
  assign setup_ph    = CE_IN & PSEL_IN & ~PENABLE_IN;
  assign access_done = CE_IN & PSEL_IN & PENABLE_IN & pready_q;
  assign idx         = reg_index(PADDR_IN);
  assign mapped      = (PADDR_IN[ADDR_SHIFT-1:0] == 2'h0) &&
                       (idx == RX_CTL_IDX || idx == TX_EN_IDX || idx == TX_OUT_IDX ||
                        idx == STA_ADR0_IDX || idx == STA_ADR1_IDX || idx == STA_ADR2_IDX);

  // read mux; the control, enable and outcome registers carry fixed identifier codes in the low bits
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    unique case (1'b1)
      idx == RX_CTL_IDX:   rd_word = {rx_ctl_q, RX_CTL_ID};
      idx == TX_EN_IDX:    rd_word = {tx_en_q, TX_EN_ID};
      idx == TX_OUT_IDX:   rd_word = {out_q, TX_OUT_ID};
      idx == STA_ADR0_IDX: rd_word = sta0_q;
      idx == STA_ADR1_IDX: rd_word = sta1_q;
      idx == STA_ADR2_IDX: rd_word = sta2_q;
      default:             rd_word = 16'h0000;
    endcase
  end

  // apb answer: ready and data are set in the setup cycle, so the access phase has no wait
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (CE_IN) begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~mapped;
      if (setup_ph) begin
        prdata_q <= (mapped && !PWRITE_IN) ? {16'h0000, rd_word} : 32'h0000_0000;
      end
    end
  end

  // merged write words of the two control registers, identifier bits kept in place
  logic [15:0] rx_ctl_wr;
  logic [15:0] tx_en_wr;
  assign rx_ctl_wr = merge16({rx_ctl_q, RX_CTL_ID}, PWDATA_IN, PSTRB_IN);
  assign tx_en_wr  = merge16({tx_en_q, TX_EN_ID}, PWDATA_IN, PSTRB_IN);

  // software writable configuration; a load from the configuration store replaces reset values
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rx_ctl_q <= RX_CTL_RST;
      tx_en_q  <= TX_EN_RST;
      sta0_q   <= 16'h0000;
      sta1_q   <= 16'h0000;
      sta2_q   <= 16'h0000;
    end else if (CE_IN) begin
      if (CFG_LOAD_IN) begin
        rx_ctl_q <= CFG_RX_CTL_IN[15:ID_W];
        tx_en_q  <= CFG_TX_EN_IN[15:ID_W];
      end else if (access_done && PWRITE_IN && mapped) begin
        if (idx == RX_CTL_IDX) begin
          rx_ctl_q <= rx_ctl_wr[15:ID_W];
        end
        if (idx == TX_EN_IDX) begin
          tx_en_q <= tx_en_wr[15:ID_W];
        end
        if (idx == STA_ADR0_IDX) begin
          sta0_q <= merge16(sta0_q, PWDATA_IN, PSTRB_IN);
        end
        if (idx == STA_ADR1_IDX) begin
          sta1_q <= merge16(sta1_q, PWDATA_IN, PSTRB_IN);
        end
        if (idx == STA_ADR2_IDX) begin
          sta2_q <= merge16(sta2_q, PWDATA_IN, PSTRB_IN);
        end
      end
    end
  end

  // receive acceptance: address qualification, then error and length classes
  logic [47:0] station;
  logic        is_group;
  logic        addr_ok;
  logic        bad_chk;
  logic        is_short;
  logic        is_long;
  logic        frame_ok;
  assign station  = {sta0_q[7:0], sta0_q[15:8], sta1_q[7:0], sta1_q[15:8], sta2_q[7:0], sta2_q[15:8]};
  assign is_group = RX_DEST_IN[GROUP_BIT];
  assign addr_ok  = rx_ctl_q[B_ANY-ID_W] |
                    (rx_ctl_q[B_HASH_STA-ID_W] & ~is_group & RX_HASH_HIT_IN) |
                    (rx_ctl_q[B_GROUP-ID_W] & is_group & RX_HASH_HIT_IN) |
                    (rx_ctl_q[B_STATION-ID_W] & (RX_DEST_IN == station)) |
                    (rx_ctl_q[B_ONES-ID_W] & (RX_DEST_IN == ALL_ONES));
  assign bad_chk  = ~RX_CHECK_OK_IN;
  assign is_short = RX_LENGTH_IN < LEN_MIN_GOOD;
  assign is_long  = RX_LENGTH_IN > LEN_MAX_GOOD;
  assign frame_ok = addr_ok &&
                    (RX_LENGTH_IN >= LEN_FLOOR) &&
                    (!bad_chk || rx_ctl_q[B_BADCHK-ID_W]) &&
                    (!is_short || rx_ctl_q[B_SHORT-ID_W]) &&
                    (!is_long || rx_ctl_q[B_LONG-ID_W]) &&
                    (bad_chk || is_short || is_long || rx_ctl_q[B_GOOD-ID_W]);

  // registered verdict, one pulse per finished frame
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rx_acc_q   <= 1'b0;
      rx_dis_q   <= 1'b0;
      rx_trunc_q <= 1'b0;
    end else if (CE_IN) begin
      rx_acc_q   <= RX_DONE_IN & frame_ok;
      rx_dis_q   <= RX_DONE_IN & ~frame_ok;
      rx_trunc_q <= RX_DONE_IN & frame_ok & is_long;
    end
  end

  // two-stage synchronisers for the transceiver pins
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      crs_sync_q <= 2'b00;
      col_sync_q <= 2'b00;
      col_last_q <= 1'b0;
    end else if (CE_IN) begin
      crs_sync_q <= {crs_sync_q[0], CARRIER_SENSE_IN};
      col_sync_q <= {col_sync_q[0], COLLISION_IN};
      col_last_q <= col_sync_q[1];
    end
  end

  logic col_rise;
  assign col_rise = col_sync_q[1] & ~col_last_q;

  // transmit supervision: next state and the outcome of the attempt
  always_comb begin
    state_d   = state_q;
    coll_d    = coll_q;
    commit    = 1'b0;
    ev_ok     = 1'b0;
    ev_sqe    = 1'b0;
    ev_late   = 1'b0;
    ev_jab    = 1'b0;
    ev_max    = 1'b0;
    abort_now = 1'b0;
    unique case (state_q)
      TX_IDLE: begin
        if (TX_START_IN) begin
          state_d = TX_SEND;
          coll_d  = TX_FIRST_IN ? 5'd0 : coll_q;
        end
      end
      TX_SEND: begin
        if (col_rise && bit_cnt_q >= LATE_CYCLES[10:0]) begin
          ev_late   = 1'b1;
          abort_now = 1'b1;
          commit    = 1'b1;
          state_d   = TX_IDLE;
        end else if (col_rise) begin
          coll_d  = coll_q + 5'd1;
          ev_max  = (coll_d == MAX_COLL);
          commit  = 1'b1;
          state_d = TX_IDLE;
        end else if (jab_cnt_q >= JABBER_CYCLES[19:0]) begin
          ev_jab    = 1'b1;
          abort_now = 1'b1;
          commit    = 1'b1;
          state_d   = TX_IDLE;
        end else if (TX_END_IN && aui_q) begin
          state_d = TX_SQE;
        end else if (TX_END_IN) begin
          ev_ok   = 1'b1;
          commit  = 1'b1;
          state_d = TX_IDLE;
        end
      end
      TX_SQE: begin
        if (col_sync_q[1]) begin
          ev_ok   = 1'b1;
          commit  = 1'b1;
          state_d = TX_IDLE;
        end else if (sqe_cnt_q >= SQE_CYCLES[7:0]) begin
          ev_ok   = 1'b1;
          ev_sqe  = 1'b1;
          commit  = 1'b1;
          state_d = TX_IDLE;
        end
      end
      default: begin
        state_d = TX_IDLE; // unused code falls back to idle
      end
    endcase
  end

  // attempt counters and sticky carrier-loss note
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q   <= TX_IDLE;
      bit_cnt_q <= 11'd0;
      jab_cnt_q <= 20'd0;
      sqe_cnt_q <= 8'd0;
      coll_q    <= 5'd0;
      loss_q    <= 1'b0;
      aui_q     <= 1'b0;
    end else if (CE_IN) begin
      state_q <= state_d;
      coll_q  <= coll_d;
      if (state_q == TX_IDLE && TX_START_IN) begin
        bit_cnt_q <= 11'd0;
        jab_cnt_q <= 20'd0;
        aui_q     <= TX_AUI_IN;
        loss_q    <= 1'b0;
      end else if (state_q == TX_SEND) begin
        if (bit_cnt_q != 11'h7FF) begin
          bit_cnt_q <= bit_cnt_q + 11'd1;
        end
        jab_cnt_q <= jab_cnt_q + 20'd1;
        if (TX_PREAMBLE_END_IN && aui_q && !crs_sync_q[1]) begin
          loss_q <= 1'b1;
        end
      end
      sqe_cnt_q <= (state_q == TX_SQE) ? sqe_cnt_q + 8'd1 : 8'd0;
    end
  end

  // outcome word of the finished attempt
  logic [9:0] new_out;
  assign new_out = {ev_max, coll_d[3:0], ev_jab, ev_late,
                    ev_ok & ~ev_jab & ~ev_late & ~ev_max,
                    ev_sqe, loss_q};

  // outcome register: a commit wins over the clear of a read
  logic read_out;
  assign read_out = access_done & ~PWRITE_IN & (idx == TX_OUT_IDX) & mapped;
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      out_q       <= 10'h000;
      out_dirty_q <= 1'b0;
    end else if (CE_IN) begin
      if (commit) begin
        out_q <= new_out;
      end else if (read_out && !out_dirty_q) begin
        out_q <= 10'h000;
      end
      if (commit) begin
        out_dirty_q <= 1'b1;
      end else if (setup_ph) begin
        out_dirty_q <= 1'b0;
      end
    end
  end

  // gated interrupt and transmit control pulses
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_q    <= 1'b0;
      abort_q  <= 1'b0;
      badchk_q <= 1'b0;
      giveup_q <= 1'b0;
    end else if (CE_IN) begin
      irq_q    <= commit && ((new_out[B_OVERLONG-ID_W:0] & tx_en_q[B_OVERLONG-ID_W:0]) != 5'h00 ||
                             (new_out[B_MAXCOLL-ID_W] & tx_en_q[B_MAXCOLL-ID_W]) ||
                             (coll_d != 5'd0 && tx_en_q[B_ANYCOLL-ID_W]));
      abort_q  <= abort_now;
      badchk_q <= ev_late;
      giveup_q <= ev_max;
    end
  end

  assign PRDATA_OUT             = prdata_q;
  assign PREADY_OUT             = pready_q;
  assign PSLVERR_OUT            = pslverr_q;
  assign RX_ACCEPT_OUT          = rx_acc_q;
  assign RX_DISCARD_OUT         = rx_dis_q;
  assign RX_TRUNCATE_OUT        = rx_trunc_q;
  assign TX_IRQ_OUT             = irq_q;
  assign TX_ABORT_OUT           = abort_q;
  assign TX_FORCE_BAD_CHECK_OUT = badchk_q;
  assign TX_GIVE_UP_OUT         = giveup_q;

  // checks
  sequence s_late_hit;
    CE_IN && state_q == TX_SEND && col_rise && bit_cnt_q >= LATE_CYCLES[10:0];
  endsequence
  sequence s_abort_seen;
    ##1 TX_ABORT_OUT && TX_FORCE_BAD_CHECK_OUT;
  endsequence

  a_ident_read: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    setup_ph && !PWRITE_IN && idx == TX_EN_IDX && mapped |=> PRDATA_OUT[5:0] == TX_EN_ID)
    else $error("identifier bits wrong");
  a_short_floor: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    CE_IN && RX_DONE_IN && RX_LENGTH_IN < LEN_FLOOR |=> !RX_ACCEPT_OUT && RX_DISCARD_OUT)
    else $error("tiny frame accepted");
  a_ones_accept: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    CE_IN && RX_DONE_IN && rx_ctl_q[B_ONES-ID_W] && RX_DEST_IN == ALL_ONES && RX_CHECK_OK_IN &&
    rx_ctl_q[B_GOOD-ID_W] && RX_LENGTH_IN == LEN_MIN_GOOD |=> RX_ACCEPT_OUT)
    else $error("all-ones frame not accepted");
  a_late_abort: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    s_late_hit |-> s_abort_seen ##0 out_q[B_LATE-ID_W])
    else $error("late collision not handled");
  a_success_excl: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    out_q[B_SUCCESS-ID_W] |-> !out_q[B_LATE-ID_W] && !out_q[B_OVERLONG-ID_W] && !out_q[B_MAXCOLL-ID_W])
    else $error("success with failure flag");
  a_read_clears: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    read_out && !commit && !out_dirty_q |=> out_q == 10'h000)
    else $error("outcome not cleared by read");
  a_irq_gated: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    CE_IN && commit && tx_en_q == 10'h000 |=> !TX_IRQ_OUT)
    else $error("interrupt with all enables clear");
  a_heartbeat_wait: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    CE_IN && state_q == TX_SEND && state_d == TX_SQE ##1 (CE_IN && !col_sync_q[1])[*8] |->
    ##[1:130] (state_q == TX_IDLE || !CE_IN || col_sync_q[1]))
    else $error("heartbeat wait not bounded");
  a_max_giveup: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    CE_IN && state_q == TX_SEND && col_rise && bit_cnt_q < LATE_CYCLES[10:0] && coll_q == 5'd15
    |=> TX_GIVE_UP_OUT && out_q[B_MAXCOLL-ID_W])
    else $error("sixteenth collision not abandoned");
endmodule

// ### rtl/mac_filter_pkg.sv
/*
  constants shared by the receive acceptance filter and transmit outcome block:
  register indices, field positions, reset values, identifier bits, timing counts.
  assumes a 20 MHz system clock and a 10 Mb/s medium (one bit time = two cycles).
*/
// Notes on behaviour
// - low six bits of the receive control, transmit enable and outcome registers always read their fixed identifier code.
// - a frame is accepted only if its destination passes an enabled address criterion.
// - hashed-station enable accepts individual destinations that hit the hash filter.
// - any-address enable passes every destination through the address filter.
// - good-frame enable accepts correct-check frames of 64 to 1518 bytes.
// - group-hashed enable accepts multicast destinations that hit the hash filter.
// - station-match enable accepts destinations equal to the six-byte station address.
// - all-ones enable accepts destinations that are 48 bits of ones.
// - bad-check enable accepts qualified frames with check errors, else discarded.
// - short-frame enable accepts qualified frames under 64 bytes; under 8 always dropped.
// - long-frame enable accepts qualified frames over 1518, truncated; else discarded.
// - receive control resets to 0x0005 unless a configuration load supplies another value.
// - each transmit enable bit gates the interrupt of its matching event.
// - on the attachment port, missing carrier at preamble end flags carrier loss.
// - on the attachment port, no collision within 64 bit times after end flags heartbeat.
// - success flag set only if fully sent with overlong, late, sixteen clear.
// - collision after 512 bit times forces bad check, ends sending, flags late.
// - sending beyond 26 ms is cut off and flagged overlong.
// - collision count of the last packet sits in bits E down to B.
// - sixteenth normal collision abandons the packet and sets the sixteen flag.
// - reading the outcome register clears its event bits; reset value 0x0008.
// - interrupt enable register resets to 0x0007 unless a configuration load overrides.
package mac_filter_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] RX_CTL_IDX   = 12'h104;
  localparam logic [11:0] TX_EN_IDX    = 12'h106;
  localparam logic [11:0] TX_OUT_IDX   = 12'h128;
  localparam logic [11:0] STA_ADR0_IDX = 12'h158;
  localparam logic [11:0] STA_ADR1_IDX = 12'h15A;
  localparam logic [11:0] STA_ADR2_IDX = 12'h15C;
  localparam int          ADDR_SHIFT   = 2;
  // identifier codes and reset values
  localparam logic [5:0]  RX_CTL_ID    = 6'h05;
  localparam logic [5:0]  TX_EN_ID     = 6'h07;
  localparam logic [5:0]  TX_OUT_ID    = 6'h08;
  localparam logic [9:0]  RX_CTL_RST   = 10'h000;
  localparam logic [9:0]  TX_EN_RST    = 10'h000;
  localparam int          ID_W         = 6;
  // receive control bit positions
  localparam int B_HASH_STA = 6;
  localparam int B_ANY      = 7;
  localparam int B_GOOD     = 8;
  localparam int B_GROUP    = 9;
  localparam int B_STATION  = 10;
  localparam int B_ONES     = 11;
  localparam int B_BADCHK   = 12;
  localparam int B_SHORT    = 13;
  localparam int B_LONG     = 14;
  // transmit enable and outcome bit positions
  localparam int B_CARRIER  = 6;
  localparam int B_HEART    = 7;
  localparam int B_SUCCESS  = 8;
  localparam int B_LATE     = 9;
  localparam int B_OVERLONG = 10;
  localparam int B_ANYCOLL  = 11;
  localparam int B_CNT_LO   = 11;
  localparam int B_CNT_HI   = 14;
  localparam int B_MAXCOLL  = 15;
  // frame length limits in bytes, all-ones address and group bit position
  localparam logic [15:0] LEN_MIN_GOOD = 16'd64;
  localparam logic [15:0] LEN_MAX_GOOD = 16'd1518;
  localparam logic [15:0] LEN_FLOOR    = 16'd8;
  localparam logic [47:0] ALL_ONES     = 48'hFFFF_FFFF_FFFF;
  localparam int          GROUP_BIT    = 40;
  // timing, collision limit and transmit states
  localparam int CLK_HZ       = 20_000_000;
  localparam int BIT_HZ       = 10_000_000;
  localparam int BIT_CYCLES   = CLK_HZ / BIT_HZ;
  localparam int LATE_BITS    = 512;
  localparam int SQE_BITS     = 64;
  localparam int JABBER_US    = 26_000;
  localparam int LATE_CYCLES  = LATE_BITS * BIT_CYCLES;
  localparam int SQE_CYCLES   = SQE_BITS * BIT_CYCLES;
  localparam int JABBER_CYC   = JABBER_US * (CLK_HZ / 1_000_000);
  localparam logic [4:0] MAX_COLL = 5'd16;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_SQE} tx_state_t;
endpackage

// ### test/medium_model.sv
/* medium side model: echoes carrier while we send, collides on request and
   answers each frame end with a heartbeat; assumes the bench clock */
`timescale 1ns/1ps
module medium_model (
  // bench side
  input  wire logic clk_in,
  input  wire logic sending_in,
  input  wire logic carrier_en_in,
  input  wire logic coll_req_in,
  input  wire logic sqe_en_in,
  input  wire logic end_in,
  // pins
  output logic      crs_out,
  output logic      col_out
);
  int cnt_q = 0;
  // carrier follows our own transmission on a healthy line
  assign crs_out = sending_in & carrier_en_in;
  // six-cycle burst on request, heartbeat burst twenty cycles after end
  always @(posedge clk_in) begin
    if (coll_req_in) cnt_q <= 1;
    else if (end_in && sqe_en_in) cnt_q <= -20;
    else if (cnt_q != 0) cnt_q <= (cnt_q == 6) ? 0 : (cnt_q == -1) ? 1 : cnt_q + 1;
  end
  assign col_out = cnt_q > 0;
endmodule

// ### test/tb_top.sv
/* bench for the receive filter and transmit outcome block: table of filter
   cases, then hand-written transmit and reset cases; assumes apb zero wait */
`timescale 1ns/1ps
module tb_top;
  import mac_filter_pkg::*;
  typedef struct packed {logic [15:0] c; logic [47:0] d; logic h, k; logic [15:0] l; logic [2:0] e;} row_t;
  localparam logic [47:0] B = ALL_ONES, S = 48'h0002_0304_0506;
  localparam logic [47:0] I = 48'h0010_2030_4050, M = 48'h0100_5E00_0001;
  localparam logic [11:0] A_RX = 12'h410, A_TE = 12'h418, A_OU = 12'h4A0;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rxd = 0, hh = 0, ok = 0;
  logic st = 0, fi = 0, aui = 0, pe = 0, te = 0, snd = 0, cen = 1, creq = 0, sqe = 1;
  logic ce = 1, cld = 0;
  logic [3:0] stb = 4'hF;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, rdv;
  logic [47:0] dst = '0;
  logic [15:0] len = '0;
  logic rdy, err, erv, acc, dis, trn, abt, bad, gvu, irq, crs, col;
  int fail_count = 0, checked = 0, irq_n = 0, abt_n = 0, bad_n = 0, gvu_n = 0;
  row_t rows [15] = '{
    '{16'h0900, B, 1'b0, 1'b1, 16'h0040, 3'h4}, '{16'h0100, B, 1'b0, 1'b1, 16'h0040, 3'h2},
    '{16'h0180, I, 1'b0, 1'b1, 16'h05EE, 3'h4}, '{16'h0500, S, 1'b0, 1'b1, 16'h0064, 3'h4},
    '{16'h0500, I, 1'b0, 1'b1, 16'h0064, 3'h2}, '{16'h0300, M, 1'b1, 1'b1, 16'h0064, 3'h4},
    '{16'h0300, M, 1'b0, 1'b1, 16'h0064, 3'h2}, '{16'h0140, I, 1'b1, 1'b1, 16'h0064, 3'h4},
    '{16'h0180, I, 1'b0, 1'b0, 16'h0064, 3'h2}, '{16'h1080, I, 1'b0, 1'b0, 16'h0064, 3'h4},
    '{16'h0180, I, 1'b0, 1'b1, 16'h003F, 3'h2}, '{16'h2080, I, 1'b0, 1'b1, 16'h003F, 3'h4},
    '{16'h2080, I, 1'b0, 1'b1, 16'h0007, 3'h2}, '{16'h0180, I, 1'b0, 1'b1, 16'h05EF, 3'h2},
    '{16'h4080, I, 1'b0, 1'b1, 16'h05EF, 3'h5}};
  // design under test, jabber count shortened but above the late window
  mac_rx_filter_tx_status #(.JABBER_CYCLES(2000)) u_dut (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PSTRB_IN(stb), .PRDATA_OUT(prd),
    .PREADY_OUT(rdy), .PSLVERR_OUT(err), .CFG_LOAD_IN(cld), .CFG_RX_CTL_IN(16'h0D3F),
    .CFG_TX_EN_IN(16'h0938), .RX_DONE_IN(rxd), .RX_DEST_IN(dst), .RX_HASH_HIT_IN(hh),
    .RX_CHECK_OK_IN(ok), .RX_LENGTH_IN(len), .RX_ACCEPT_OUT(acc), .RX_DISCARD_OUT(dis),
    .RX_TRUNCATE_OUT(trn), .TX_START_IN(st), .TX_FIRST_IN(fi), .TX_AUI_IN(aui),
    .TX_PREAMBLE_END_IN(pe), .TX_END_IN(te), .TX_ABORT_OUT(abt), .TX_FORCE_BAD_CHECK_OUT(bad),
    .TX_GIVE_UP_OUT(gvu), .TX_IRQ_OUT(irq), .CARRIER_SENSE_IN(crs), .COLLISION_IN(col));
  // far side of the transmit path
  medium_model u_medium (.clk_in(clk), .sending_in(snd), .carrier_en_in(cen), .coll_req_in(creq),
    .sqe_en_in(sqe), .end_in(te), .crs_out(crs), .col_out(col));
  // clock
  always #25 clk = ~clk;
  // pulse counters for the transmit outputs
  always @(posedge clk) begin
    if (irq === 1'b1) irq_n++;
    if (abt === 1'b1) abt_n++;
    if (bad === 1'b1) bad_n++;
    if (gvu === 1'b1) gvu_n++;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    rdv = prd;
    erv = err;
    psel <= 0; pen <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [15:0] m);
    apb(0, a, 0);
    chk($sformatf("reg %h", a), {16'h0000, e & m}, rdv & {16'hFFFF, m});
  endtask
  // one transmit attempt: collision, end and length in cycles after start
  task automatic send(input logic u, input logic f, input int c, input int e, input int n);
    @(posedge clk);
    st <= 1; aui <= u; fi <= f; snd <= 1;
    @(posedge clk);
    st <= 0;
    for (int i = 1; i <= n; i++) begin
      pe <= (i == 8); te <= (i == e); creq <= (i == c);
      @(posedge clk);
    end
    pe <= 0; te <= 0; creq <= 0; snd <= 0;
    repeat (140) @(posedge clk);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rd(A_RX, 16'h0005, 16'hFFFF);
    rd(A_TE, 16'h0007, 16'hFFFF);
    rd(A_OU, 16'h0008, 16'hFFFF);
    apb(0, 12'h7FC, 0);
    chk("unmapped error", 1, erv);
    apb(1, 12'h560, 32'h0200);
    apb(1, 12'h568, 32'h0403);
    apb(1, 12'h570, 32'h0605);
    foreach (rows[i]) begin
      apb(1, A_RX, {16'h0000, rows[i].c});
      rd(A_RX, rows[i].c | 16'h0005, 16'hFFFF);
      @(posedge clk);
      rxd <= 1; dst <= rows[i].d; hh <= rows[i].h; ok <= rows[i].k; len <= rows[i].l;
      @(posedge clk);
      rxd <= 0;
      @(posedge clk);
      chk("rx verdict", rows[i].e, {acc, dis, trn});
    end
    apb(1, A_TE, 32'h0100);
    rd(A_TE, 16'h0107, 16'hFFFF);
    send(0, 1, 0, 30, 40);
    rd(A_OU, 16'h0108, 16'hFFFF);
    rd(A_OU, 16'h0008, 16'hFFFF);
    chk("irq count", 1, irq_n);
    cen <= 0; sqe <= 0;
    send(1, 1, 0, 30, 40);
    rd(A_OU, 16'h01C8, 16'hFFFF);
    cen <= 1; sqe <= 1;
    send(1, 1, 0, 30, 40);
    rd(A_OU, 16'h0108, 16'hFFFF);
    apb(1, A_TE, 32'h0000);
    send(0, 1, 10, 0, 20);
    rd(A_OU, 16'h0808, 16'hFFFF);
    for (int i = 0; i < 15; i++) send(0, 0, 10, 0, 20);
    rd(A_OU, 16'h8008, 16'hFFFF);
    chk("give up", 1, gvu_n);
    send(0, 1, 1050, 0, 1100);
    rd(A_OU, 16'h0208, 16'h87FF);
    chk("abort", 1, abt_n);
    chk("bad check", 1, bad_n);
    send(0, 1, 0, 0, 2100);
    rd(A_OU, 16'h0408, 16'h87FF);
    chk("abort", 2, abt_n);
    chk("irq count", 3, irq_n);
    apb(1, A_TE, 32'h0800);
    send(0, 1, 10, 0, 20);
    chk("irq count", 4, irq_n);
    apb(1, A_OU, 32'h0000FFFF);
    rd(A_OU, 16'h0808, 16'hFFFF);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd(A_RX, 16'h0005, 16'hFFFF);
    rd(A_TE, 16'h0007, 16'hFFFF);
    // lane 0 only: control bits 7:6 land, identifier bits still read fixed
    stb <= 4'h1;
    apb(1, A_RX, 32'h0000_FFFF);
    stb <= 4'hF;
    rd(A_RX, 16'h00C5, 16'hFFFF);
    // configuration load replaces the control values, low six bits ignored
    @(posedge clk);
    cld <= 1;
    @(posedge clk);
    cld <= 0;
    rd(A_RX, 16'h0D05, 16'hFFFF);
    rd(A_TE, 16'h0907, 16'hFFFF);
    // a frame summary offered while the enable is low must be ignored
    @(posedge clk);
    ce <= 0;
    rxd <= 1;
    dst <= B;
    ok <= 1;
    len <= 16'h0040;
    @(posedge clk);
    ce <= 1;
    rxd <= 0;
    @(posedge clk);
    chk("frozen verdict", 0, {acc, dis, trn});
    print_verdict();
  end
endmodule
